/* File: rtl/mpc_config_loader.sv */
// Behaviour
// - Capture every multi-mode pin at power-up and on each restore command.
// - Each pin is classed as low, open, high or resistor to ground.
// - A strapped pin resolves to one of three levels.
// - Two strapped pins combine into one of nine settings.
// - Resistor mode decodes an index of at most 31 settings.
// - Address and voltage ceiling come only from pins; others bus-settable.
// - Bus slave address formed from the two address-select pins.
// - Voltage ceiling is 10% above the voltage from the two select pins.
// - Captured values bus-readable; writable except address and ceiling.
// - Fixed selectable frequency PWM; duty from compensated digital error.
// - Duty is capped so the low-side switch is on each period.
// - Monitored values compared against preset limits raise an alert.
// - Drive a power-good output usable as processor power-on reset.
`timescale 1ns/10ps
`default_nettype none
module mpc_config_loader #(
  parameter int PERIOD_W = 8
) (
  input  wire logic                CLOCK,
  input  wire logic                ARST_N,
  input  wire logic                RESTORE,
  input  wire mpc_pkg::mpc_pin_t   ADDR_SEL0,
  input  wire mpc_pkg::mpc_pin_t   ADDR_SEL1,
  input  wire mpc_pkg::mpc_pin_t   VOUT_SEL0,
  input  wire mpc_pkg::mpc_pin_t   VOUT_SEL1,
  input  wire mpc_pkg::mpc_pin_t   CFG_SEL,
  input  wire logic                HOST_WR_VOUT,
  input  wire logic                HOST_WR_CFG,
  input  wire logic [9:0]          HOST_WDATA,
  input  wire logic [PERIOD_W-1:0] SW_PERIOD,
  input  wire logic signed [7:0]   ERR_CODE,
  input  wire logic [3:0]          COMP_GAIN,
  input  wire logic [9:0]          MON_VALUE,
  input  wire logic [9:0]          MON_LIMIT,
  output logic [6:0]               DEV_ADDR,
  output logic [9:0]               VOUT_SET,
  output logic [9:0]               VOUT_CEIL,
  output logic [6:0]               CFG_VALUE,
  output logic                     LOADED,
  output logic                     PWM_HI,
  output logic [7:0]               DUTY,
  output logic                     ALERT,
  output logic                     POWER_GOOD
);

  // Three-level value of a strapped pin; a resistor pin counts as low
  function automatic logic [1:0] lvl(input mpc_pkg::mpc_pin_t p);
    case (p.kind)
      mpc_pkg::MPC_LOW:  lvl = 2'h0;
      mpc_pkg::MPC_OPEN: lvl = 2'h1;
      mpc_pkg::MPC_HIGH: lvl = 2'h2;
      default:           lvl = 2'h0;
    endcase
  endfunction

  // Nine-way combination: first pin is the minor digit
  function automatic logic [3:0] nine(input mpc_pkg::mpc_pin_t lo,
                                      input mpc_pkg::mpc_pin_t hi);
    nine = 4'(lvl(hi) * 3 + lvl(lo));
  endfunction

  // Resistor index clamped to the decodable range
  function automatic logic [4:0] ridx(input mpc_pkg::mpc_pin_t p);
    if (p.index > 5'(mpc_pkg::MPC_RES_MAX - 1))
      ridx = 5'(mpc_pkg::MPC_RES_MAX - 1);
    else
      ridx = p.index;
  endfunction

  // Strap table in 10 mV units
  function automatic logic [9:0] vtab(input logic [3:0] s);
    case (s)
      4'h0:    vtab = 10'h03c;
      4'h1:    vtab = 10'h050;
      4'h2:    vtab = 10'h064;
      4'h3:    vtab = 10'h078;
      4'h4:    vtab = 10'h096;
      4'h5:    vtab = 10'h0b4;
      4'h6:    vtab = 10'h0fa;
      4'h7:    vtab = 10'h14a;
      default: vtab = 10'h1f4;
    endcase
  endfunction

  logic       sampled;
  logic       next_sampled;
  logic [6:0] next_dev_addr;
  logic [9:0] next_vout_set;
  logic [9:0] next_vout_ceil;
  logic [6:0] next_cfg_value;
  logic [9:0] vout_pins;
  logic       capture;

  assign capture = !sampled || RESTORE;

  always_comb
  begin
    // Voltage from pins: two resistors give coarse and fine, else nine-way
    if (VOUT_SEL0.kind == mpc_pkg::MPC_RES &&
        VOUT_SEL1.kind == mpc_pkg::MPC_RES)
      vout_pins = 10'(ridx(VOUT_SEL1) * mpc_pkg::MPC_VOUT_FINE_STEPS)
                  + 10'(ridx(VOUT_SEL0));
    else
      vout_pins = vtab(nine(VOUT_SEL0, VOUT_SEL1));
    next_sampled   = 1'b1;
    next_dev_addr  = DEV_ADDR;
    next_vout_set  = VOUT_SET;
    next_vout_ceil = VOUT_CEIL;
    next_cfg_value = CFG_VALUE;
    if (capture)
    begin
      // Address uses the two address pins; only pins may set it
      next_dev_addr  = mpc_pkg::MPC_ADDR_BASE
                       + 7'(nine(ADDR_SEL0, ADDR_SEL1));
      next_vout_set  = vout_pins;
      next_vout_ceil = 10'((32'(vout_pins) * mpc_pkg::MPC_CEIL_NUM)
                           / mpc_pkg::MPC_CEIL_DEN);
      if (CFG_SEL.kind == mpc_pkg::MPC_RES)
        next_cfg_value = {2'h1, ridx(CFG_SEL)};
      else
        next_cfg_value = {5'h00, lvl(CFG_SEL)};
    end
    else
    begin
      // Host may overwrite only bus-settable values
      if (HOST_WR_VOUT)
        next_vout_set = HOST_WDATA;
      if (HOST_WR_CFG)
        next_cfg_value = HOST_WDATA[6:0];
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sampled   <= 1'b0;
      DEV_ADDR  <= mpc_pkg::MPC_ADDR_BASE;
      VOUT_SET  <= mpc_pkg::MPC_VOUT_RST;
      VOUT_CEIL <= mpc_pkg::MPC_VOUT_RST;
      CFG_VALUE <= 7'h00;
    end
    else
    begin
      sampled   <= next_sampled;
      DEV_ADDR  <= next_dev_addr;
      VOUT_SET  <= next_vout_set;
      VOUT_CEIL <= next_vout_ceil;
      CFG_VALUE <= next_cfg_value;
    end
  end

  assign LOADED = sampled;

  // PWM: constant period counter, duty from gained error
  logic [PERIOD_W-1:0] cnt;
  logic [PERIOD_W-1:0] next_cnt;
  logic [7:0]          next_duty;
  logic                next_pwm;
  logic signed [12:0]  acc;
  logic [7:0]          cap;
  logic [PERIOD_W-1:0] cnt_scaled;

  always_comb
  begin
    acc = 13'(signed'({1'b0, DUTY}))
          + 13'(ERR_CODE * signed'({1'b0, COMP_GAIN}) >>> 2);
    cap = mpc_pkg::MPC_DUTY_MAX;
    if (acc < 13'sh0000)
      next_duty = 8'h00;
    else if (acc > 13'(signed'({1'b0, cap})))
      next_duty = cap;
    else
      next_duty = acc[7:0];
    // Duty only moves at the start of a period
    if (cnt != '0)
      next_duty = DUTY;
    if (cnt + 1'b1 >= SW_PERIOD || SW_PERIOD == '0)
      next_cnt = '0;
    else
      next_cnt = cnt + 1'b1;
    cnt_scaled = PERIOD_W'((32'(DUTY) * 32'(SW_PERIOD)) >> 8);
    next_pwm   = sampled && (next_cnt < cnt_scaled);
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cnt    <= '0;
      DUTY   <= 8'h00;
      PWM_HI <= 1'b0;
    end
    else
    begin
      cnt    <= next_cnt;
      DUTY   <= next_duty;
      PWM_HI <= next_pwm;
    end
  end

  // Alert on limit breach, power good once captured, at or below ceiling and not alerting
  logic next_alert;
  logic next_pg;

  always_comb
  begin
    next_alert = sampled && (MON_VALUE > MON_LIMIT);
    next_pg    = sampled && (MON_VALUE <= VOUT_CEIL)
                 && !next_alert;
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ALERT      <= 1'b0;
      POWER_GOOD <= 1'b0;
    end
    else
    begin
      ALERT      <= next_alert;
      POWER_GOOD <= next_pg;
    end
  end

  property p_first_capture;
    @(posedge CLOCK) disable iff (!ARST_N)
    !sampled |=> sampled && VOUT_SET == $past(vout_pins);
  endproperty
  a_first_capture: assert property (p_first_capture)
    else $error("no capture");

  property p_addr_hold;
    @(posedge CLOCK) disable iff (!ARST_N)
    sampled && !RESTORE |=> DEV_ADDR == $past(DEV_ADDR);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved");

  // Pin-derived voltage of the last capture, reference for the ceiling
  logic [9:0] pin_snap;
  logic [9:0] next_pin_snap;

  assign next_pin_snap = capture ? vout_pins : pin_snap;

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      pin_snap <= mpc_pkg::MPC_VOUT_RST;
    else
      pin_snap <= next_pin_snap;
  end

  property p_ceil;
    @(posedge CLOCK) disable iff (!ARST_N)
    sampled |-> 32'(VOUT_CEIL) == (32'(pin_snap) * mpc_pkg::MPC_CEIL_NUM)
                                  / mpc_pkg::MPC_CEIL_DEN;
  endproperty
  a_ceil: assert property (p_ceil)
    else $error("ceiling wrong");

  property p_duty_cap;
    @(posedge CLOCK) disable iff (!ARST_N)
    DUTY <= mpc_pkg::MPC_DUTY_MAX;
  endproperty
  a_duty_cap: assert property (p_duty_cap)
    else $error("duty over cap");

  property p_host_wr;
    @(posedge CLOCK) disable iff (!ARST_N)
    sampled && !RESTORE && HOST_WR_VOUT |=> VOUT_SET == $past(HOST_WDATA);
  endproperty
  a_host_wr: assert property (p_host_wr)
    else $error("host write lost");

  property p_alert;
    @(posedge CLOCK) disable iff (!ARST_N)
    sampled && MON_VALUE > MON_LIMIT |=> ALERT;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert missing");

  property p_pg;
    @(posedge CLOCK) disable iff (!ARST_N)
    POWER_GOOD |-> !ALERT ##0 sampled;
  endproperty
  a_pg: assert property (p_pg)
    else $error("pg with alert");

  property p_cfg_hold;
    @(posedge CLOCK) disable iff (!ARST_N)
    sampled && !RESTORE && !HOST_WR_CFG |=> $stable(CFG_VALUE);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("cfg changed");

  property p_restore;
    @(posedge CLOCK) disable iff (!ARST_N)
    RESTORE |=> VOUT_SET == $past(vout_pins);
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore missed");

  property p_pg_idle;
    @(posedge CLOCK) disable iff (!ARST_N)
    !sampled |=> !POWER_GOOD;
  endproperty
  a_pg_idle: assert property (p_pg_idle)
    else $error("pg before load");

  // Last count of each period must leave the high side off
  property p_low_side;
    @(posedge CLOCK) disable iff (!ARST_N)
    SW_PERIOD != '0 && cnt == SW_PERIOD - 1'b1 |-> !PWM_HI;
  endproperty
  a_low_side: assert property (p_low_side)
    else $error("no low-side time");

endmodule
`default_nettype wire

/* File: rtl/mpc_pkg.sv */
package mpc_pkg;

  // Classified connection kind of one multi-mode pin
  typedef enum logic [1:0] {
    MPC_LOW,
    MPC_OPEN,
    MPC_HIGH,
    MPC_RES
  } mpc_kind_t;

  // Measurement of one pin delivered by the analog front end
  typedef struct packed {
    mpc_kind_t  kind;
    logic [4:0] index;
  } mpc_pin_t;

  localparam int MPC_IDX_W       = 5;
  localparam int MPC_RES_MAX     = 31;
  localparam int MPC_VOUT_W      = 10;
  localparam int MPC_DUTY_W      = 8;
  localparam int MPC_ADDR_W      = 7;
  localparam logic [6:0] MPC_ADDR_BASE = 7'h20;
  localparam logic [9:0] MPC_VOUT_RST  = 10'h03c;
  localparam logic [7:0] MPC_DUTY_MAX  = 8'he6;
  localparam int MPC_CEIL_NUM    = 11;
  localparam int MPC_CEIL_DEN    = 10;
  localparam logic [9:0] MPC_VOUT_FINE_STEPS = 10'h019;

endpackage

/* File: verification/mpc_board_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mpc_board_model (
  output var mpc_pkg::mpc_pin_t [4:0] pins
);

  // Strap or resistor on pin n; strapped pins carry no usable index
  task automatic strap(
    input int                  n,
    input mpc_pkg::mpc_kind_t  k,
    input logic [4:0]          idx
  );
    if (k == mpc_pkg::MPC_RES)
      pins[n] = {k, idx};
    else
      pins[n] = {k, ~idx};
  endtask

  initial
  begin
    for (int i = 0; i < 5; i++)
      pins[i] = {mpc_pkg::MPC_OPEN, 5'h15};
  end

endmodule
`default_nettype wire

/* File: verification/mpc_config_loader_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module mpc_config_loader_tb_top;
  localparam int PW = 4;
  logic              clock = 1'b0;
  logic              arst_n = 1'b0;
  logic              restore = 1'b0;
  logic              wr_vout = 1'b0;
  logic              wr_cfg = 1'b0;
  logic [9:0]        wdata = 10'h000;
  logic [9:0]        mon_value = 10'h000;
  logic [9:0]        mon_limit = 10'h3ff;
  logic [PW-1:0]     sw_period = 4'h8;
  logic signed [7:0] err_code = 8'sh00;
  logic [3:0]        comp_gain = 4'h1;
  logic [6:0]        dev_addr, cfg_value;
  logic [9:0]        vout_set, vout_ceil;
  logic [7:0]        duty;
  logic              loaded, pwm_hi, alert, power_good;
  mpc_pkg::mpc_pin_t [4:0] pins;
  int                err_count = 0;
  int                num_checks = 0;
  int                hi_count = 0;

  mpc_board_model board (.pins(pins));

  mpc_config_loader #(.PERIOD_W(PW)) dut (
    .CLOCK(clock), .ARST_N(arst_n), .RESTORE(restore),
    .ADDR_SEL0(pins[0]), .ADDR_SEL1(pins[1]), .VOUT_SEL0(pins[2]),
    .VOUT_SEL1(pins[3]), .CFG_SEL(pins[4]), .HOST_WR_VOUT(wr_vout),
    .HOST_WR_CFG(wr_cfg), .HOST_WDATA(wdata), .SW_PERIOD(sw_period),
    .ERR_CODE(err_code), .COMP_GAIN(comp_gain), .MON_VALUE(mon_value),
    .MON_LIMIT(mon_limit), .DEV_ADDR(dev_addr), .VOUT_SET(vout_set),
    .VOUT_CEIL(vout_ceil), .CFG_VALUE(cfg_value), .LOADED(loaded),
    .PWM_HI(pwm_hi), .DUTY(duty), .ALERT(alert), .POWER_GOOD(power_good));

  always #25 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Nine pin-strap output voltages in 10 mV units, V0 the minor digit
  function automatic logic [9:0] vtab_exp(input int s);
    case (s)
      0:       vtab_exp = 10'h03c;
      1:       vtab_exp = 10'h050;
      2:       vtab_exp = 10'h064;
      3:       vtab_exp = 10'h078;
      4:       vtab_exp = 10'h096;
      5:       vtab_exp = 10'h0b4;
      6:       vtab_exp = 10'h0fa;
      7:       vtab_exp = 10'h14a;
      default: vtab_exp = 10'h1f4;
    endcase
  endfunction

  // Restore pulse, one cycle wide, then an idle edge so pulses never abut
  task automatic capture();
    restore = 1'b1;
    step(1);
    restore = 1'b0;
    step(1);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    step(16);
    arst_n = 1'b1;
    step(1);
    check(loaded, 1'b1);
    check(dev_addr, 7'h24);
    check(vout_set, 10'h096);
    check(pwm_hi, 1'b0);
    for (int a = 0; a < 9; a++)
    begin
      board.strap(0, mpc_pkg::mpc_kind_t'(a % 3), 5'h00);
      board.strap(1, mpc_pkg::mpc_kind_t'(a / 3), 5'h00);
      board.strap(2, mpc_pkg::mpc_kind_t'(a % 3), 5'h00);
      board.strap(3, mpc_pkg::mpc_kind_t'(a / 3), 5'h00);
      board.strap(4, mpc_pkg::mpc_kind_t'(a % 3), 5'h00);
      capture();
      check(dev_addr, mpc_pkg::MPC_ADDR_BASE + 7'(a));
      check(vout_set, vtab_exp(a));
      check(vout_ceil, vtab_exp(a) * 11 / 10);
      check(cfg_value, 7'(a % 3));
    end
    board.strap(0, mpc_pkg::MPC_LOW, 5'h00);
    board.strap(1, mpc_pkg::MPC_LOW, 5'h00);
    step(3);
    check(dev_addr, 7'h28);
    $display("strap test done");
    board.strap(2, mpc_pkg::MPC_RES, 5'd8);
    board.strap(3, mpc_pkg::MPC_RES, 5'd5);
    board.strap(4, mpc_pkg::MPC_RES, 5'd31);
    capture();
    check(dev_addr, 7'h20);
    check(vout_set, 10'd133);
    check(vout_ceil, 10'd146);
    check(cfg_value, 7'h3e);
    $display("resistor test done");
    wr_vout = 1'b1;
    wdata = 10'h0c8;
    step(1);
    wr_vout = 1'b0;
    wr_cfg = 1'b1;
    wdata = 10'h255;
    step(1);
    wr_cfg = 1'b0;
    check(vout_set, 10'h0c8);
    check(cfg_value, 7'h55);
    check(vout_ceil, 10'd146);
    check(dev_addr, 7'h20);
    restore = 1'b1;
    wr_vout = 1'b1;
    wdata = 10'h3ff;
    step(1);
    restore = 1'b0;
    wr_vout = 1'b0;
    check(vout_set, 10'd133);
    $display("host test done");
    err_code = 8'sh7f;
    comp_gain = 4'hf;
    for (int i = 0; i < 40; i++)
    begin
      step(1);
      check(duty <= mpc_pkg::MPC_DUTY_MAX, 1'b1);
      if (i >= 32)
        hi_count += int'(pwm_hi);
    end
    check(duty, mpc_pkg::MPC_DUTY_MAX);
    check(hi_count < 8, 1'b1);
    check(hi_count > 0, 1'b1);
    err_code = 8'sh80;
    step(10);
    check(duty, 8'h00);
    check(pwm_hi, 1'b0);
    err_code = 8'sh00;
    $display("duty test done");
    mon_value = 10'h200;
    mon_limit = 10'h100;
    step(2);
    check(alert, 1'b1);
    check(power_good, 1'b0);
    mon_value = 10'h050;
    step(2);
    check(alert, 1'b0);
    check(power_good, 1'b1);
    $display("alert test done");
    tally_and_finish();
  end

  initial
  begin
    #(50 * 2000);
    err_count++;
    tally_and_finish();
  end

endmodule
`default_nettype wire
